/* common/fbh_pkg.sv */
// Package for the parallel flash bus-operation host controller
package fbh_pkg;
  localparam int ADDR_W = 19;
  localparam int DATA_W = 8;
  localparam int SECT_HI_W = 3;
  // Strobe timing in ns, converted to 5 ns cycles, rounded up as least times
  localparam int CLK_PERIOD_NS = 5;
  localparam int T_ACC_NS = 120;
  localparam int T_WP_NS = 50;
  localparam int T_WPH_NS = 30;
  localparam int T_AS_NS = 5;
  localparam int ACC_CYC = (T_ACC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WP_CYC = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WPH_CYC = (T_WPH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int AS_CYC = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CNT_W = 8;
  // Command codes and unlock addresses of the command sequences
  localparam logic [7:0] CMD_RESET = 8'hF0;
  localparam logic [7:0] CMD_UNLK1 = 8'hAA;
  localparam logic [7:0] CMD_UNLK2 = 8'h55;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_PROG = 8'hA0;
  localparam logic [7:0] CMD_BYPASS = 8'h20;
  localparam logic [7:0] CMD_BYP_EXIT1 = 8'h90;
  localparam logic [7:0] CMD_BYP_EXIT2 = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_CHIP = 8'h10;
  localparam logic [7:0] CMD_SECT = 8'h30;
  localparam logic [18:0] ADR_UNLK1 = 19'h00555;
  localparam logic [18:0] ADR_UNLK2 = 19'h002AA;
  // Host request operations
  typedef enum logic [2:0] {
    OP_READ = 3'h0, OP_PROG = 3'h1, OP_FPROG = 3'h2, OP_SECT_ERASE = 3'h3,
    OP_CHIP_ERASE = 3'h4, OP_IDENT = 3'h5, OP_RESET = 3'h6, OP_BYPASS = 3'h7
  } fbh_op_t;
  typedef struct packed {
    fbh_op_t op;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } fbh_req_t;
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
  } fbh_strb_t;
endpackage : fbh_pkg

/* verilog/fbh_ctrl.sv */
// Host controller that drives a parallel flash through its strobe, address and data pins
// Contract
// R01: Reads hold chip select and output enable low and write enable high with a valid address.
// R02: Writes hold write enable and chip select low with output enable high.
// R03: The device starts in array read after power-up or hardware reset.
// R04: In array read the device returns array data with no command first.
// R05: The device stays in array read until a write alters its command register.
// R06: The command register has no address in the memory map and latches command, address and data.
// R07: Latched command contents steer the device state machine and thereby its function.
// R08: A fast-mode program takes two write cycles, the normal program four.
// R09: Erase targets one sector, several sectors or the whole array, by high address bits; each request here erases one sector or the whole array.
// R10: After the identification sequence reads return codes from a separate register.
// R11: During program or erase reads return status bits for polling.
// R12: Only chip select and write enable low with output enable high is a write.
// R13: With output enable high the device floats its data pins.
// R14: After a bad sequence the host issues the reset command to regain array read.
// R15: The device latches address on the later falling strobe and data on the earlier rising one.
module fbh_ctrl
  import fbh_pkg::*;
#(
  parameter int ACC_CYCLES = ACC_CYC,
  parameter int WP_CYCLES = WP_CYC,
  parameter int WPH_CYCLES = WPH_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // Request and answer
  input wire logic req_valid,
  input wire fbh_req_t req,
  output logic req_ready,
  output logic rsp_valid,
  output logic [DATA_W-1:0] rsp_data,
  output logic bypass_active,
  // Flash pins
  output fbh_strb_t strb,
  output logic [ADDR_W-1:0] address_pins,
  input wire logic [DATA_W-1:0] data_pins_i,
  output logic [DATA_W-1:0] data_pins_o,
  output logic data_pins_oe
);
  typedef enum logic [4:0] {
    S_IDLE = 5'b00001, S_SETUP = 5'b00010, S_PULSE = 5'b00100, S_HOLD = 5'b01000, S_READ = 5'b10000
  } fbh_state_t;

  fbh_state_t st_r, st_nxt;
  fbh_strb_t strb_r, strb_nxt;
  logic [ADDR_W-1:0] addr_r, addr_nxt;
  logic [DATA_W-1:0] wdat_r, wdat_nxt, rdat_r, rdat_nxt;
  logic oe_r, oe_nxt, rv_r, rv_nxt, byp_r, byp_nxt, rdy_r, rdy_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic [2:0] cyc_r, cyc_nxt, ncyc_r, ncyc_nxt;
  fbh_req_t cur_r, cur_nxt;

  // Write cycle n of the sequence for an operation
  function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input fbh_req_t r, input logic [2:0] n,
                                                        input logic byp);
    logic [ADDR_W+DATA_W-1:0] w;
    w = {ADR_UNLK1, CMD_RESET};
    unique case (r.op)
      OP_RESET: w = {r.addr, CMD_RESET}; // R14
      OP_FPROG: w = (n == 3'h0) ? {r.addr, CMD_PROG} : {r.addr, r.data}; // R08
      OP_BYPASS: begin
        if (byp) w = (n == 3'h0) ? {r.addr, CMD_BYP_EXIT1} : {r.addr, CMD_BYP_EXIT2};
        else if (n == 3'h0) w = {ADR_UNLK1, CMD_UNLK1};
        else if (n == 3'h1) w = {ADR_UNLK2, CMD_UNLK2};
        else w = {ADR_UNLK1, CMD_BYPASS};
      end
      default: begin
        if (n == 3'h0) w = {ADR_UNLK1, CMD_UNLK1};
        else if (n == 3'h1) w = {ADR_UNLK2, CMD_UNLK2};
        else if (r.op == OP_IDENT) w = {ADR_UNLK1, CMD_IDENT}; // R10
        else if (r.op == OP_PROG) w = (n == 3'h2) ? {ADR_UNLK1, CMD_PROG} : {r.addr, r.data}; // R08
        else if (n == 3'h2) w = {ADR_UNLK1, CMD_ERASE};
        else if (n == 3'h3) w = {ADR_UNLK1, CMD_UNLK1};
        else if (n == 3'h4) w = {ADR_UNLK2, CMD_UNLK2};
        else if (r.op == OP_CHIP_ERASE) w = {ADR_UNLK1, CMD_CHIP}; // R09
        else w = {r.addr, CMD_SECT}; // R09
      end
    endcase
    return w;
  endfunction : seq_word

  // Number of write cycles per operation
  function automatic logic [2:0] seq_len(input fbh_op_t op, input logic byp);
    logic [2:0] n;
    n = 3'h1;
    unique case (op)
      OP_READ, OP_RESET: n = 3'h1;
      OP_FPROG: n = 3'h2; // R08
      OP_BYPASS: n = byp ? 3'h2 : 3'h3;
      OP_PROG: n = 3'h4; // R08
      OP_IDENT: n = 3'h3;
      OP_SECT_ERASE, OP_CHIP_ERASE: n = 3'h6;
      default: n = 3'h1;
    endcase
    return n;
  endfunction : seq_len

  wire logic take = rdy_r && req_valid;
  wire logic [ADDR_W+DATA_W-1:0] word = seq_word(cur_r, cyc_r, byp_r);
  wire logic cnt_done = (cnt_r == '0);
  wire logic last_cyc = (cyc_r + 3'h1 == ncyc_r);
  // Fast program without bypass mode would be garbage to the device, so it is sent as normal program
  wire fbh_req_t req_fix = (req.op == OP_FPROG && !byp_r) ? '{op: OP_PROG, addr: req.addr, data: req.data} : req;

  always_comb begin
    st_nxt = st_r;
    strb_nxt = strb_r;
    addr_nxt = addr_r;
    wdat_nxt = wdat_r;
    rdat_nxt = rdat_r;
    oe_nxt = oe_r;
    rv_nxt = 1'b0;
    byp_nxt = byp_r;
    rdy_nxt = rdy_r;
    cnt_nxt = cnt_done ? cnt_r : cnt_r - 1'b1;
    cyc_nxt = cyc_r;
    ncyc_nxt = ncyc_r;
    cur_nxt = cur_r;
    unique case (st_r)
      S_IDLE: begin
        if (take) begin
          cur_nxt = req_fix;
          rdy_nxt = 1'b0;
          cyc_nxt = 3'h0;
          ncyc_nxt = seq_len(req_fix.op, byp_r);
          if (req_fix.op == OP_READ) begin
            // Array data, id codes or polling status all read the same way
            addr_nxt = req_fix.addr; // R04 R10 R11
            strb_nxt = '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1}; // R01
            oe_nxt = 1'b0; // R13
            cnt_nxt = CNT_W'(ACC_CYCLES);
            st_nxt = S_READ;
          end else begin
            st_nxt = S_SETUP;
            cnt_nxt = CNT_W'(AS_CYC);
          end
        end
      end
      S_SETUP: begin
        addr_nxt = word[DATA_W +: ADDR_W];
        wdat_nxt = word[DATA_W-1:0];
        oe_nxt = 1'b1;
        strb_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
        if (cnt_done) begin
          // Address settles before both strobes fall, data stands until after they rise
          strb_nxt = '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0}; // R02 R12 R15
          cnt_nxt = CNT_W'(WP_CYCLES);
          st_nxt = S_PULSE;
        end
      end
      S_PULSE: begin
        if (cnt_done) begin
          strb_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1}; // R15
          cnt_nxt = CNT_W'(WPH_CYCLES);
          st_nxt = S_HOLD;
        end
      end
      S_HOLD: begin
        if (cnt_done) begin
          oe_nxt = 1'b0;
          if (last_cyc) begin
            if (cur_r.op == OP_BYPASS) byp_nxt = !byp_r;
            if (cur_r.op == OP_RESET) byp_nxt = 1'b0; // R14
            rv_nxt = 1'b1;
            rdy_nxt = 1'b1;
            st_nxt = S_IDLE;
          end else begin
            cyc_nxt = cyc_r + 3'h1;
            cnt_nxt = CNT_W'(AS_CYC);
            st_nxt = S_SETUP;
          end
        end
      end
      S_READ: begin
        if (cnt_done) begin
          rdat_nxt = data_pins_i;
          strb_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
          rv_nxt = 1'b1;
          rdy_nxt = 1'b1;
          st_nxt = S_IDLE;
        end
      end
      default: begin
        st_nxt = S_IDLE;
        rdy_nxt = 1'b1;
        strb_nxt = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= S_IDLE;
      strb_r <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      addr_r <= '0;
      wdat_r <= '0;
      rdat_r <= '0;
      oe_r <= 1'b0;
      rv_r <= 1'b0;
      byp_r <= 1'b0;
      rdy_r <= 1'b1;
      cnt_r <= '0;
      cyc_r <= '0;
      ncyc_r <= '0;
      cur_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
      strb_r <= strb_nxt;
      addr_r <= addr_nxt;
      wdat_r <= wdat_nxt;
      rdat_r <= rdat_nxt;
      oe_r <= oe_nxt;
      rv_r <= rv_nxt;
      byp_r <= byp_nxt;
      rdy_r <= rdy_nxt;
      cnt_r <= cnt_nxt;
      cyc_r <= cyc_nxt;
      ncyc_r <= ncyc_nxt;
      cur_r <= cur_nxt;
    end
  end

  assign req_ready = rdy_r;
  assign rsp_valid = rv_r;
  assign rsp_data = rdat_r;
  assign bypass_active = byp_r;
  assign strb = strb_r;
  assign address_pins = addr_r;
  assign data_pins_o = wdat_r;
  assign data_pins_oe = oe_r;

  // Never drive data while the flash may drive it
  property p_no_contention;
    @(posedge clk) disable iff (!rst_n) !(oe_r && !strb_r.oe_n);
  endproperty
  a_no_contention: assert property (p_no_contention) else $error("data bus contention"); // R13

  property p_write_strobes;
    @(posedge clk) disable iff (!rst_n) !strb_r.we_n |-> (!strb_r.ce_n && strb_r.oe_n && oe_r);
  endproperty
  a_write_strobes: assert property (p_write_strobes) else $error("bad write strobe combination"); // R02

  property p_read_strobes;
    @(posedge clk) disable iff (!rst_n) !strb_r.oe_n |-> (!strb_r.ce_n && strb_r.we_n);
  endproperty
  a_read_strobes: assert property (p_read_strobes) else $error("bad read strobe combination"); // R01

  property p_addr_stable;
    @(posedge clk) disable iff (!rst_n) (clk_en && !strb_r.we_n && $past(!strb_r.we_n)) |-> $stable(addr_r);
  endproperty
  a_addr_stable: assert property (p_addr_stable) else $error("address moved during write pulse"); // R15

  property p_data_after_rise;
    @(posedge clk) disable iff (!rst_n) (clk_en && $rose(strb_r.we_n)) |-> $stable(wdat_r) && oe_r;
  endproperty
  a_data_after_rise: assert property (p_data_after_rise) else $error("data changed at write rise"); // R15

  property p_read_done;
    @(posedge clk) disable iff (!rst_n) $rose(st_r == S_READ) |-> ##[1:300] rv_r;
  endproperty
  a_read_done: assert property (p_read_done) else $error("read not answered"); // R04

  property p_reset_clears_bypass;
    @(posedge clk) disable iff (!rst_n) (clk_en && st_r == S_HOLD && cnt_done && last_cyc && cur_r.op == OP_RESET)
      |=> !byp_r;
  endproperty
  a_reset_clears_bypass: assert property (p_reset_clears_bypass) else $error("reset left bypass set"); // R14

  property p_fprog_len;
    @(posedge clk) disable iff (!rst_n) (clk_en && take && req.op == OP_FPROG && byp_r) |=> ncyc_r == 3'h2;
  endproperty
  a_fprog_len: assert property (p_fprog_len) else $error("fast program length wrong"); // R08
endmodule : fbh_ctrl

/* verif/fbh_flash_model.sv */
// Behavioural parallel flash device facing the host controller
module fbh_flash_model
  import fbh_pkg::*;
#(
  parameter int ACC_NS = 100,
  parameter logic [7:0] MAKER = 8'h3C, // Arbitrary value
  parameter logic [7:0] PART = 8'h6D // Arbitrary value
) (
  // Pins from the host
  input wire fbh_strb_t strb,
  input wire logic [ADDR_W-1:0] address_pins,
  input wire logic [DATA_W-1:0] data_bus,
  // Device drive and write count
  output logic [DATA_W-1:0] q_o,
  output int wr_count
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] mem [0:(1<<ADDR_W)-1];
  logic [7:0] rd_val, last_q, st, d;
  logic [ADDR_W-1:0] a_lat;
  logic ident, byp, busy;
  int step;
  wire wr = !strb.ce_n && !strb.we_n && strb.oe_n;
  wire rd = !strb.ce_n && !strb.oe_n && strb.we_n;
  wire [7:0] val_d;
  assign #(ACC_NS) val_d = rd_val;
  // Released bus shows the inverse of the last byte, so a stale sample cannot pass
  assign q_o = rd ? val_d : ~last_q;
  always_comb rd_val = ident ? (address_pins[0] ? PART : MAKER) : busy ? st : mem[address_pins];
  initial begin
    foreach (mem[i]) mem[i] = 8'hFF;
    ident = 0;
    byp = 0;
    busy = 0;
    step = 0;
    wr_count = 0;
    last_q = 8'h00;
  end
  always @(posedge wr) a_lat = address_pins;
  always @(negedge rd) begin
    last_q = val_d;
    busy = 0;
  end
  always @(negedge wr) begin
    wr_count++;
    d = data_bus;
    if (d == CMD_RESET) begin
      step = 0;
      ident = 0;
      byp = 0;
    end else case (step)
      0: step = byp ? (d == CMD_PROG ? 9 : d == CMD_BYP_EXIT1 ? 8 : 0) : (d == CMD_UNLK1 && a_lat == ADR_UNLK1);
      1: step = d == CMD_UNLK2 && a_lat == ADR_UNLK2 ? 2 : 0;
      2: begin
        ident = d == CMD_IDENT;
        byp = d == CMD_BYPASS;
        step = d == CMD_PROG ? 9 : d == CMD_ERASE ? 3 : 0;
      end
      3: step = d == CMD_UNLK1 ? 4 : 0;
      4: step = d == CMD_UNLK2 ? 5 : 0;
      8: begin
        byp = d != CMD_BYP_EXIT2;
        step = 0;
      end
      9: begin
        mem[a_lat] = mem[a_lat] & d;
        st = {~d[7], 7'h00};
        busy = 1;
        step = 0;
      end
      default: begin
        for (int k = 0; k < (1 << ADDR_W); k++)
          if (d == CMD_CHIP || (d == CMD_SECT && k[18:16] == a_lat[18:16])) mem[k] = 8'hFF;
        st = 8'h00;
        busy = d == CMD_CHIP || d == CMD_SECT;
        step = 0;
      end
    endcase
  end
endmodule : fbh_flash_model

/* verif/test_fbh_ctrl.sv */
// Self-checking bench for the flash host controller against the device model
module test_fbh_ctrl import fbh_pkg::*; ;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MAKER = 8'h3C; // Arbitrary value
  localparam logic [7:0] PART = 8'h6D; // Arbitrary value
  logic clk = 0;
  logic rst_n = 0;
  logic clk_en = 1;
  logic req_valid = 0;
  fbh_req_t req = '0;
  logic req_ready, rsp_valid, bypass_active, data_pins_oe;
  logic [DATA_W-1:0] rsp_data, data_pins_o, q_o, q;
  logic [ADDR_W-1:0] address_pins;
  fbh_strb_t strb;
  int wr_count, w0;
  int bad_count = 0;
  int total_checks = 0;
  int cycles = 0;
  wire [DATA_W-1:0] data_bus = data_pins_oe ? data_pins_o : q_o;
  fbh_ctrl fbh_ctrl_inst (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .bypass_active(bypass_active),
    .strb(strb), .address_pins(address_pins), .data_pins_i(data_bus), .data_pins_o(data_pins_o),
    .data_pins_oe(data_pins_oe));
  fbh_flash_model #(.MAKER(MAKER), .PART(PART)) fbh_flash_model_inst (.strb(strb),
    .address_pins(address_pins), .data_bus(data_bus), .q_o(q_o), .wr_count(wr_count));
  initial forever #2.5 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      bad_count++;
      conclude();
    end
  end
  always @(negedge clk) begin
    if (!strb.oe_n && (data_pins_oe !== 1'b0 || strb.we_n !== 1'b1)) check(1, 0);
    if (!strb.we_n && strb.oe_n !== 1'b1) check(1, 0);
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check
  task automatic conclude();
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic do_op(input fbh_op_t op, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    int n;
    n = 0;
    req_valid = 1;
    req = '{op, a, d};
    while (req_ready !== 1'b1 && n < 100) begin
      @(posedge clk);
      #1 n++;
    end
    @(posedge clk);
    #1 req_valid = 0;
    while (rsp_valid !== 1'b1 && n < 900) begin
      @(posedge clk);
      #1 n++;
    end
    check(rsp_valid, 1);
    q = rsp_data;
  endtask : do_op
  task automatic rd(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    do_op(OP_READ, a, 8'h00);
    check(q, exp);
  endtask : rd
  task automatic s_reset();
    check(strb, 3'b111);
    check({req_ready, rsp_valid, data_pins_oe}, 3'b100);
  endtask : s_reset
  task automatic s_prog();
    rd(19'h7FFFF, 8'hFF);
    w0 = wr_count;
    do_op(OP_PROG, 19'h12345, 8'h5A);
    check(wr_count - w0, 4);
    rd(19'h12345, 8'h80);
    rd(19'h12345, 8'h5A);
  endtask : s_prog
  task automatic s_bypass();
    do_op(OP_BYPASS, 19'h0, 8'h00);
    check(bypass_active, 1);
    w0 = wr_count;
    do_op(OP_FPROG, 19'h54321, 8'hC3);
    check(wr_count - w0, 2);
    rd(19'h54321, 8'h00);
    rd(19'h54321, 8'hC3);
    do_op(OP_BYPASS, 19'h0, 8'h00);
    check(bypass_active, 0);
    w0 = wr_count;
    do_op(OP_FPROG, 19'h00010, 8'h0F);
    check(wr_count - w0, 4);
    rd(19'h00010, 8'h80);
  endtask : s_bypass
  task automatic s_ident();
    do_op(OP_IDENT, 19'h0, 8'h00);
    rd(19'h00000, MAKER);
    rd(19'h00001, PART);
    do_op(OP_RESET, 19'h0, 8'h00);
    rd(19'h12345, 8'h5A);
  endtask : s_ident
  // Reset must also drop fast mode, and a low clock enable must hold the strobes, req_ready and rsp_valid where they stand
  task automatic s_freeze();
    do_op(OP_BYPASS, 19'h0, 8'h00);
    do_op(OP_RESET, 19'h0, 8'h00);
    check(bypass_active, 0);
    clk_en = 0;
    req = '{OP_READ, 19'h54321, 8'h00};
    req_valid = 1;
    repeat (3) @(posedge clk);
    #1 check({strb, req_ready, rsp_valid}, 5'h1F);
    clk_en = 1;
    rd(19'h54321, 8'hC3);
  endtask : s_freeze
  task automatic s_erase();
    do_op(OP_SECT_ERASE, 19'h10000, 8'h00);
    rd(19'h12345, 8'h00);
    rd(19'h12345, 8'hFF);
    rd(19'h54321, 8'hC3);
    do_op(OP_SECT_ERASE, 19'h50000, 8'h00);
    rd(19'h54321, 8'h00);
    rd(19'h54321, 8'hFF);
    rd(19'h00010, 8'h0F);
    do_op(OP_CHIP_ERASE, 19'h0, 8'h00);
    rd(19'h00010, 8'h00);
    rd(19'h00010, 8'hFF);
  endtask : s_erase
  initial begin
    repeat (2) @(posedge clk);
    s_reset();
    repeat (2) @(posedge clk);
    #1 rst_n = 1;
    s_prog();
    s_bypass();
    s_ident();
    s_freeze();
    s_erase();
    conclude();
  end
endmodule : test_fbh_ctrl
